// [hdl/ebh_defines.svh]
// Timing and field constants for the external bus handshake block
`ifndef EBH_DEFINES_SVH
`define EBH_DEFINES_SVH
`define EBH_MIN_READY_WAITS 3'h2
`define EBH_WAIT_W          3
`define EBH_MC_DIV          2'h2
`define EBH_SPACE_DATA      2'h0
`define EBH_SPACE_PROG      2'h1
`define EBH_SPACE_IO        2'h2
`endif

// [hdl/ebh_pkg.sv]
// Types for the external bus handshake block
package ebh_pkg;
  typedef enum logic [1:0]
  {
    EBH_SP_DATA = 2'h0,
    EBH_SP_PROG = 2'h1,
    EBH_SP_IO   = 2'h2
  } ebh_space_t;
  typedef enum logic [2:0]
  {
    EBH_IDLE  = 3'h0,
    EBH_ADDR  = 3'h1,
    EBH_SWAIT = 3'h3,
    EBH_RWAIT = 3'h2,
    EBH_DONE  = 3'h6,
    EBH_HOLD  = 3'h4
  } ebh_state_t;
endpackage

// [hdl/ebh_bus_ctl.sv]
// External bus control: strobes, direction, ready wait states, hold arbitration
`timescale 1ns/1ps
`include "ebh_defines.svh"
// ----------------------------------------------------------------
// How it works
// - Ready low extends access one machine cycle, then samples ready again.
// - Ready sampled only with two or more wait states, after they finish.
// - Direction output high by default, low only during an external write.
// - I/O strobe high except during an I/O-space access.
// - On hold grant, float address, data, control; assert hold acknowledge.
// - In hold mode direction and I/O strobe float.
// - Emulation control low floats direction, strobes, acknowledge and clock out.
// - Clock output toggles at machine-cycle rate, cycles bounded by rising edges.
// - Memory strobe low only for data/program access; floats in hold.
// - One space select low while its address is valid; all float in hold.
// ----------------------------------------------------------------
module ebh_bus_ctl
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // CPU request side
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire logic              reqWrite,
  input  wire ebh_pkg::ebh_space_t reqSpace,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0] reqWdata,
  input  wire logic [`EBH_WAIT_W-1:0] swWaits,
  output logic                   rspValid,
  output logic [DATA_W-1:0]      rspRdata,
  // External bus
  output logic [ADDR_W-1:0]      addrOut,
  output logic                   addrOe,
  output logic [DATA_W-1:0]      dataOut,
  output logic                   dataOe,
  input  wire logic [DATA_W-1:0] dataIn,
  input  wire logic              ready,
  output logic                   readWriteN,
  output logic                   readWriteOe,
  output logic                   ioSpaceStrobeN,
  output logic                   ioSpaceStrobeOe,
  output logic                   memorySpaceStrobeN,
  output logic                   memorySpaceStrobeOe,
  output logic                   dataSpaceSelectN,
  output logic                   programSpaceSelectN,
  output logic                   ioSpaceSelectN,
  output logic                   spaceSelectOe,
  // Hold arbitration and emulation
  input  wire logic              holdReqN,
  output logic                   busGrantAckN,
  output logic                   busGrantAckOe,
  input  wire logic              emulationFloatCtl,
  output logic                   machineCycleClkOut,
  output logic                   machineCycleClkOe
);
  import ebh_pkg::*;

  // ----------------------------------------------------------------
  // Machine cycle enable
  // ----------------------------------------------------------------
  logic [1:0] divCnt_q;
  logic       mcTick;
  logic       machine_cycle_clk_out_q;
  assign mcTick = (divCnt_q == `EBH_MC_DIV - 2'h1);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      divCnt_q <= 2'h0;
    else
      divCnt_q <= mcTick ? 2'h0 : divCnt_q + 2'h1;
  end

  // Rising edge as each tick ends, falling halfway
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      machine_cycle_clk_out_q <= 1'b1;
    else
      machine_cycle_clk_out_q <= mcTick;
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  ebh_state_t               state_q;
  logic [`EBH_WAIT_W-1:0]   waitCnt_q;
  logic                     write_q;
  ebh_space_t               space_q;
  logic [ADDR_W-1:0]        addr_q;
  logic [DATA_W-1:0]        wdata_q;
  logic                     useReady;

  // Ready only honoured with enough programmed waits
  assign useReady = (swWaits >= `EBH_MIN_READY_WAITS);
  assign reqReady = (state_q == EBH_IDLE) && mcTick && holdReqN;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q   <= EBH_IDLE;
      waitCnt_q <= '0;
    end
    else if (mcTick)
    begin
      case (state_q)
        EBH_IDLE:
          if (!holdReqN)
            state_q <= EBH_HOLD;
          else if (reqValid)
            state_q <= EBH_ADDR;
        EBH_ADDR:
        begin
          waitCnt_q <= swWaits;
          state_q   <= (swWaits != '0) ? EBH_SWAIT : EBH_DONE;
        end
        EBH_SWAIT:
        begin
          waitCnt_q <= waitCnt_q - {{(`EBH_WAIT_W-1){1'b0}}, 1'b1};
          if (waitCnt_q == {{(`EBH_WAIT_W-1){1'b0}}, 1'b1})
            state_q <= useReady ? EBH_RWAIT : EBH_DONE;
        end
        EBH_RWAIT:
          if (ready)
            state_q <= EBH_DONE;
        EBH_DONE:
          state_q <= EBH_IDLE;
        EBH_HOLD:
          if (holdReqN)
            state_q <= EBH_IDLE;
        default:
          state_q <= EBH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      write_q <= 1'b0;
      space_q <= EBH_SP_DATA;
      addr_q  <= '0;
      wdata_q <= '0;
    end
    else if (reqReady && reqValid)
    begin
      write_q <= reqWrite;
      space_q <= reqSpace;
      addr_q  <= reqAddr;
      wdata_q <= reqWdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rspValid <= 1'b0;
      rspRdata <= '0;
    end
    else
    begin
      rspValid <= mcTick && (state_q == EBH_DONE);
      if (mcTick && (state_q == EBH_DONE) && !write_q)
        rspRdata <= dataIn;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic active;
  logic inHold;
  logic emuOn;
  assign active = (state_q != EBH_IDLE) && (state_q != EBH_HOLD);
  assign inHold = (state_q == EBH_HOLD);
  assign emuOn  = emulationFloatCtl;

  assign addrOut             = addr_q;
  assign dataOut             = wdata_q;
  assign addrOe              = !inHold;
  assign dataOe              = !inHold && active && write_q;
  assign readWriteN          = !(active && write_q);
  assign readWriteOe         = !inHold && emuOn;
  assign ioSpaceStrobeN      = !(active && space_q == EBH_SP_IO);
  assign ioSpaceStrobeOe     = !inHold && emuOn;
  assign memorySpaceStrobeN  = !(active && space_q != EBH_SP_IO);
  assign memorySpaceStrobeOe = !inHold && emuOn;
  assign dataSpaceSelectN    = !(active && space_q == EBH_SP_DATA);
  assign programSpaceSelectN = !(active && space_q == EBH_SP_PROG);
  assign ioSpaceSelectN      = !(active && space_q == EBH_SP_IO);
  assign spaceSelectOe       = !inHold && emuOn;
  assign busGrantAckN        = !inHold;
  assign busGrantAckOe       = emuOn;
  assign machineCycleClkOut  = machine_cycle_clk_out_q;
  assign machineCycleClkOe   = emuOn;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ready_extend: assert property (@(posedge clk) disable iff (!rst_n)
    (mcTick && state_q == EBH_RWAIT && !ready) |=> state_q == EBH_RWAIT)
    else $error("ready low did not extend access");
  a_ready_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (mcTick && state_q == EBH_SWAIT && waitCnt_q == {{(`EBH_WAIT_W-1){1'b0}}, 1'b1}
      && !useReady) |=> state_q == EBH_DONE)
    else $error("ready sampled with too few waits");
  a_rw_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !readWriteN |-> (active && write_q))
    else $error("direction low outside write");
  a_io_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    !ioSpaceStrobeN |-> active && space_q == EBH_SP_IO)
    else $error("io strobe low outside io access");
  a_hold_float: assert property (@(posedge clk) disable iff (!rst_n)
    !busGrantAckN |-> !addrOe && !dataOe && !memorySpaceStrobeOe)
    else $error("bus driven during hold");
  a_hold_ctl: assert property (@(posedge clk) disable iff (!rst_n)
    inHold |-> !readWriteOe && !ioSpaceStrobeOe)
    else $error("control driven in hold");
  a_emu_float: assert property (@(posedge clk) disable iff (!rst_n)
    !emulationFloatCtl |-> !busGrantAckOe && !machineCycleClkOe && !readWriteOe)
    else $error("pins driven while emulation off");
  a_clk_period: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(machine_cycle_clk_out_q) |=> !machine_cycle_clk_out_q ##1 machine_cycle_clk_out_q)
    else $error("clock out period wrong");
  a_mem_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    !memorySpaceStrobeN |-> space_q != EBH_SP_IO)
    else $error("memory strobe on io access");
  a_one_select: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0({!dataSpaceSelectN, !programSpaceSelectN, !ioSpaceSelectN}))
    else $error("more than one space select");
  a_grant_edge: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(inHold) |-> $past(state_q) == EBH_IDLE)
    else $error("hold granted mid access");

  c_write:   cover property (@(posedge clk) disable iff (!rst_n) rspValid && write_q);
  c_rwait:   cover property (@(posedge clk) disable iff (!rst_n) state_q == EBH_RWAIT && !ready);
  c_hold:    cover property (@(posedge clk) disable iff (!rst_n) $rose(inHold));
  c_io_read: cover property (@(posedge clk) disable iff (!rst_n) !ioSpaceStrobeN && readWriteN);
endmodule

// [verification/ebh_mem_model.sv]
// Behavioural external memory with a slow ready
`timescale 1ns/1ps
module ebh_mem_model
(
  // Bus side
  input  wire logic        clk,
  input  wire logic        strobeN,
  input  wire logic        readWriteN,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  slowClks,
  output logic             ready,
  output logic [15:0]      dataIn
);
  logic [7:0]  lowCnt_q;
  logic [15:0] last_q = 16'h0000;
  always_ff @(posedge clk)
  begin
    lowCnt_q <= strobeN ? 8'h00 : lowCnt_q + 8'h01;
  end
  always_ff @(posedge clk)
  begin
    last_q <= dataIn;
  end
  // Ready stays low for slowClks clocks after the strobe falls
  assign ready = strobeN || (lowCnt_q >= slowClks);
  // Released bus flips each cycle so a stale value never passes
  assign dataIn = (!strobeN && readWriteN) ? (addr ^ 16'h5A5A) : ~last_q;
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the external bus handshake block
`timescale 1ns/1ps
module tb_top;
  import ebh_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
  logic        holdReqN = 1'b1, emulationFloatCtl = 1'b1;
  ebh_space_t  reqSpace = EBH_SP_DATA;
  logic [15:0] reqAddr = 16'h0000, reqWdata = 16'h0000;
  logic [15:0] dataIn, addrOut, dataOut, rspRdata;
  logic [2:0]  swWaits = 3'h0, sel;
  logic [7:0]  slowClks = 8'h00;
  logic        reqReady, rspValid, addrOe, dataOe, ready, readWriteN, readWriteOe;
  logic        ioSpaceStrobeN, ioSpaceStrobeOe, memorySpaceStrobeN, memorySpaceStrobeOe;
  logic        dataSpaceSelectN, programSpaceSelectN, ioSpaceSelectN, spaceSelectOe;
  logic        busGrantAckN, busGrantAckOe, machineCycleClkOut, machineCycleClkOe;
  logic        sawIo, sawMem, sawRw, midGrant;
  int          n_mismatch = 0, checks_done = 0, cycles = 0, lat, fast;
  ebh_bus_ctl i_dut (.clk, .rst_n, .reqValid, .reqReady, .reqWrite, .reqSpace, .reqAddr,
    .reqWdata, .swWaits, .rspValid, .rspRdata, .addrOut, .addrOe, .dataOut, .dataOe, .dataIn,
    .ready, .readWriteN, .readWriteOe, .ioSpaceStrobeN, .ioSpaceStrobeOe, .memorySpaceStrobeN,
    .memorySpaceStrobeOe, .dataSpaceSelectN, .programSpaceSelectN, .ioSpaceSelectN,
    .spaceSelectOe, .holdReqN, .busGrantAckN, .busGrantAckOe, .emulationFloatCtl,
    .machineCycleClkOut, .machineCycleClkOe);
  ebh_mem_model i_mem (.clk, .strobeN(ioSpaceStrobeN & memorySpaceStrobeN), .readWriteN,
    .addr(addrOut), .slowClks, .ready, .dataIn);
  always #5 clk = ~clk;
  // Runs last under two hundred cycles, so this only cuts a hang
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // ----
  // One access, watched at every falling edge
  // ----
  task automatic access(input logic w, input ebh_space_t sp, input logic [2:0] sw,
                        input logic [7:0] slow, input logic hm);
    int n;
    n = 0;
    lat = 0;
    {sawIo, sawMem, sawRw, midGrant, sel} = 7'h07;
    @(posedge clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqSpace <= sp;
    reqAddr <= 16'h1230 + 16'(sp);
    reqWdata <= 16'hC0DE;
    swWaits <= sw;
    slowClks <= slow;
    do @(negedge clk); while (reqReady !== 1'b1 && ++n < 40);
    chk("reqTaken", 16'h0001, 16'(reqReady === 1'b1));
    @(posedge clk);
    reqValid <= 1'b0;
    holdReqN <= ~hm;
    while (rspValid !== 1'b1 && lat < 300)
    begin
      @(negedge clk);
      lat++;
      if (ioSpaceStrobeN === 1'b0) sawIo = 1'b1;
      if (memorySpaceStrobeN === 1'b0) sawMem = 1'b1;
      if (readWriteN === 1'b0 && dataOut === 16'hC0DE) sawRw = 1'b1;
      if (busGrantAckN === 1'b0 && rspValid !== 1'b1) midGrant = 1'b1;
      sel &= {dataSpaceSelectN, programSpaceSelectN, ioSpaceSelectN};
    end
    chk("rspDone", 16'h0001, 16'(rspValid === 1'b1));
    chk("ioStrobe", 16'(sp == EBH_SP_IO), 16'(sawIo));
    chk("memStrobe", 16'(sp != EBH_SP_IO), 16'(sawMem));
    chk("writeDir", 16'(w), 16'(sawRw));
    chk("select", 16'h0007 ^ (16'h0004 >> sp), 16'(sel));
    chk(w ? "writeData" : "readData", w ? 16'hC0DE : reqAddr ^ 16'h5A5A,
      w ? dataOut : rspRdata);
    chk("midGrant", 16'h0000, 16'(midGrant));
  endtask
  task automatic t_idle();
    @(negedge clk);
    chk("idleLevels", 16'h007F, 16'({readWriteN, ioSpaceStrobeN, memorySpaceStrobeN,
      busGrantAckN, dataSpaceSelectN, programSpaceSelectN, ioSpaceSelectN}));
    fast = machineCycleClkOut;
    @(negedge clk);
    chk("clkToggle", {15'h0000, ~fast[0]}, 16'(machineCycleClkOut));
    $display("test idle done");
  endtask
  task automatic t_spaces();
    for (int i = 0; i < 6; i++)
      access(i[0], ebh_space_t'(i / 2), 3'h0, 8'h00, 1'b0);
    $display("test spaces done");
  endtask
  task automatic t_ready();
    access(1'b0, EBH_SP_DATA, 3'h2, 8'h1E, 1'b0);
    chk("slowLatency", 16'h0001, 16'(lat >= 31 && lat <= 38));
    access(1'b0, EBH_SP_DATA, 3'h1, 8'h00, 1'b0);
    fast = lat;
    access(1'b0, EBH_SP_DATA, 3'h1, 8'h1E, 1'b0);
    chk("waitGate", 16'(fast), 16'(lat));
    $display("test ready done");
  endtask
  task automatic t_hold();
    int n;
    n = 0;
    access(1'b1, EBH_SP_IO, 3'h2, 8'h06, 1'b1);
    do @(negedge clk); while (busGrantAckN !== 1'b0 && ++n < 20);
    chk("holdFloat", 16'h0001, 16'({addrOe, dataOe, readWriteOe, ioSpaceStrobeOe,
      memorySpaceStrobeOe, spaceSelectOe, busGrantAckOe}));
    @(posedge clk);
    holdReqN <= 1'b1;
    repeat (6) @(negedge clk);
    chk("holdExit", 16'h0003, 16'({busGrantAckN, addrOe}));
    $display("test hold done");
  endtask
  task automatic t_emu();
    @(posedge clk);
    emulationFloatCtl <= 1'b0;
    repeat (2) @(negedge clk);
    chk("emuFloat", 16'h0000, 16'({readWriteOe, ioSpaceStrobeOe, memorySpaceStrobeOe,
      spaceSelectOe, busGrantAckOe, machineCycleClkOe}));
    @(posedge clk);
    emulationFloatCtl <= 1'b1;
    repeat (2) @(negedge clk);
    chk("emuDrive", 16'h003F, 16'({readWriteOe, ioSpaceStrobeOe, memorySpaceStrobeOe,
      spaceSelectOe, busGrantAckOe, machineCycleClkOe}));
    $display("test emulation done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_idle();
    t_spaces();
    t_ready();
    t_hold();
    t_emu();
    final_report();
  end
endmodule
